// ===== hdl/ias_pkg.sv
// constants, register map and alarm codes for the alarm supervisor
package ias_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned ADC_FREEZE_MS = 400;
  localparam int unsigned KEY_PERSIST_MS = 100;
  localparam int unsigned MSG_TIMEOUT_MS = 100;
  localparam int unsigned ADC_FREEZE_CYC = ADC_FREEZE_MS * (CLK_HZ / 1000);
  localparam int unsigned KEY_PERSIST_CYC = KEY_PERSIST_MS * (CLK_HZ / 1000);
  localparam int unsigned MSG_TIMEOUT_CYC = MSG_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 25;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SET_BAT = 8'h04;
  localparam logic [7:0] REG_SET_KEY = 8'h08;
  localparam logic [7:0] REG_KEY_MAX = 8'h0c;
  localparam logic [7:0] REG_KEY_MIN = 8'h10;
  localparam logic [7:0] REG_OV_LVL = 8'h14;
  localparam logic [7:0] REG_HOME_TOL = 8'h18;
  localparam logic [7:0] REG_HOME_OFF = 8'h1c;
  localparam logic [7:0] REG_ALARM = 8'h20;
  localparam logic [7:0] REG_IRQ_STAT = 8'h24;
  localparam logic [7:0] REG_IRQ_CLR = 8'h28;
  localparam logic [7:0] REG_IRQ_EN = 8'h2c;
  localparam logic [7:0] REG_CODES = 8'h30;
  localparam logic [7:0] REG_STATE = 8'h34;
  localparam int CTRL_PM_BIT = 0;
  localparam int CTRL_SENS_BIT = 1;
  localparam logic [11:0] RST_VAL12 = 12'h000;
  // ---------------------------------------------------------------
  // alarm bit positions
  // ---------------------------------------------------------------
  localparam int ALM_W = 17;
  localparam int A_ANALOG = 0, A_BAT_SET = 1, A_BUMPER = 2, A_PMOS = 3;
  localparam int A_PWR_ACQ = 4, A_HOME = 5, A_NOMSG = 6, A_BOARD = 7;
  localparam int A_KEY_HI = 8, A_KEY_LO = 9, A_SHORT = 10, A_KEY_SET = 11;
  localparam int A_WDOG = 12, A_IN_MISM = 13, A_SETPT = 14;
  localparam int A_OVERV = 15, A_UNDERV = 16;
  // alarms that open the contactor and apply the brake
  localparam logic [16:0] MASK_OPEN = 17'h1bfff;
  // ---------------------------------------------------------------
  // reported codes {canopen, display, numeric}
  // ---------------------------------------------------------------
  localparam logic [31:0] CODE_NONE = 32'h0000_0000;
  localparam logic [31:0] CODE_OTHER = 32'hff00_0000;
  localparam logic [31:0] CODE_WDOG = 32'h6010_0808;
  localparam logic [31:0] CODE_NOMSG = {16'h8130, 8'd67, 8'd248};
  localparam logic [31:0] CODE_IN_MISM = {16'hffd5, 8'd58, 8'd213};
  localparam logic [31:0] CODE_SETPT = {16'hffd4, 8'd59, 8'd212};
  localparam logic [31:0] CODE_ANALOG = {16'hfffa, 8'd96, 8'd237};
  localparam logic [31:0] CODE_OVERV = {16'hffca, 8'd77, 8'd202};
  localparam logic [31:0] CODE_UNDERV = {16'h5114, 8'd19, 8'd19};
  // ---------------------------------------------------------------
  // machine state, gray along boot-check-standby-run
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00, ST_CHECK = 2'b01, ST_STBY = 2'b11, ST_RUN = 2'b10
  } ias_state_t;
endpackage

// ===== hdl/ias_top.sv
// fault detection, alarm latching and reaction with apb registers
`timescale 1ns/1ns
`default_nettype none
module ias_top import ias_pkg::*; #(
  parameter int unsigned ADC_FREEZE = ADC_FREEZE_CYC,
  parameter int unsigned KEY_PERSIST = KEY_PERSIST_CYC,
  parameter int unsigned MSG_TIMEOUT = MSG_TIMEOUT_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic adc_done,
  input wire logic adc_changed,
  input wire logic [11:0] key_voltage,
  input wire logic [11:0] dc_link_v,
  input wire logic [2:0] high_side_on,
  input wire logic bumper_a,
  input wire logic bumper_b,
  input wire logic board_present,
  input wire logic short_detect,
  input wire logic volt_irq,
  input wire logic pwm_data_valid,
  input wire logic index_pulse,
  input wire logic [11:0] rotor_angle,
  input wire logic sup_msg,
  input wire logic watchdog_fault,
  input wire logic input_mismatch,
  input wire logic setpoint_fault,
  input wire logic motion_request,
  output logic main_contactor,
  output logic electromagnetic_brake,
  output logic traction_output,
  output logic pump_output,
  output logic valve_output,
  output logic [15:0] canopen_code,
  output logic [7:0] display_code,
  output logic [7:0] numeric_code,
  output logic irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    ias_state_t st;
    logic [1:0] boot_cnt;
    logic [ALM_W-1:0] alm;
    logic [ALM_W-1:0] irq_st;
    logic [ALM_W-1:0] irq_en;
    logic [1:0] ctrl;
    logic [11:0] set_bat;
    logic [11:0] set_key;
    logic [11:0] key_max;
    logic [11:0] key_min;
    logic [11:0] ov_lvl;
    logic [11:0] home_tol;
    logic [11:0] home_off;
    logic [CNT_W-1:0] adc_cnt;
    logic [CNT_W-1:0] khi_cnt;
    logic [CNT_W-1:0] klo_cnt;
    logic [CNT_W-1:0] msg_cnt;
    logic [4:0] s1;
    logic [4:0] s2;
    logic req_d;
    logic [31:0] prdata;
    logic [31:0] codes;
    logic contactor;
    logic brake;
    logic trac;
    logic valves;
  } ias_regs_t;

  ias_regs_t q_r;
  ias_regs_t q_nxt;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // true when v lies within plus or minus twenty percent of n
  function automatic logic in_band(input logic [11:0] v,
                                   input logic [11:0] n);
    logic [15:0] a;
    logic [15:0] lo;
    logic [15:0] hi;
    a = 16'(v) * 16'd5;
    lo = 16'(n) * 16'd4;
    hi = 16'(n) * 16'd6;
    return (a >= lo) && (a <= hi);
  endfunction

  // saturating counter step, cleared when hold is low
  function automatic logic [CNT_W-1:0] count(input logic hold,
                                             input logic [CNT_W-1:0] c);
    if (!hold) begin
      return '0;
    end
    return (&c) ? c : c + 1'b1;
  endfunction

  // code of one alarm bit
  function automatic logic [31:0] code_of(input int idx);
    case (idx)
      A_WDOG: return CODE_WDOG;
      A_NOMSG: return CODE_NOMSG;
      A_IN_MISM: return CODE_IN_MISM;
      A_SETPT: return CODE_SETPT;
      A_ANALOG: return CODE_ANALOG;
      A_OVERV: return CODE_OVERV;
      A_UNDERV: return CODE_UNDERV;
      default: return CODE_OTHER;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // synchronised pins: bumper a, bumper b, board, short, volt irq
  // ---------------------------------------------------------------
  logic bump_a_s;
  logic bump_b_s;
  logic board_s;
  logic short_s;
  logic virq_s;
  assign bump_a_s = q_r.s2[0];
  assign bump_b_s = q_r.s2[1];
  assign board_s = q_r.s2[2];
  assign short_s = q_r.s2[3];
  assign virq_s = q_r.s2[4];

  // bus decode
  logic setup;
  logic wr;
  logic mapped;
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= REG_STATE);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [ALM_W-1:0] ev;
    logic [ALM_W-1:0] clr;
    logic [11:0] diff;
    logic req_rise;
    logic comm_ok;
    logic open_c;
    ev = '0;
    clr = '0;
    diff = 12'h000;
    req_rise = 1'b0;
    comm_ok = 1'b0;
    open_c = 1'b0;
    q_nxt = q_r;
    q_nxt.s1 = {volt_irq, short_detect, board_present, bumper_b, bumper_a};
    q_nxt.s2 = q_r.s1;
    q_nxt.req_d = motion_request;
    req_rise = motion_request && !q_r.req_d;

    // machine sequence
    case (q_r.st)
      ST_BOOT: begin
        q_nxt.boot_cnt = q_r.boot_cnt + 2'd1;
        if (&q_r.boot_cnt) begin
          q_nxt.st = ST_CHECK;
        end
      end
      ST_CHECK: q_nxt.st = ST_STBY;
      ST_STBY: begin
        if (motion_request) begin
          q_nxt.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!motion_request) begin
          q_nxt.st = ST_STBY;
        end
      end
      default: q_nxt.st = ST_BOOT;
    endcase

    if (adc_done) begin
      q_nxt.adc_cnt = adc_changed ? '0 : q_r.adc_cnt;
    end
    q_nxt.adc_cnt = count(!(adc_done && adc_changed), q_nxt.adc_cnt);
    ev[A_ANALOG] = q_r.adc_cnt >= CNT_W'(ADC_FREEZE);

    // startup checks, taken once in the check state
    if (q_r.st == ST_CHECK) begin
      ev[A_BAT_SET] = !in_band(key_voltage, q_r.set_bat);
      ev[A_PWR_ACQ] = q_r.ctrl[CTRL_PM_BIT] && q_r.ctrl[CTRL_SENS_BIT] &&
                      !pwm_data_valid;
      ev[A_BOARD] = !board_s;
      ev[A_KEY_SET] = !in_band(key_voltage, q_r.set_key);
    end

    ev[A_BUMPER] = bump_a_s && bump_b_s;
    ev[A_PMOS] = (dc_link_v == 12'h000) && (|high_side_on);

    diff = rotor_angle - q_r.home_off;
    ev[A_HOME] = index_pulse && (diff > q_r.home_tol) &&
                 ((12'h000 - diff) > q_r.home_tol);

    q_nxt.msg_cnt = count(!sup_msg, q_r.msg_cnt);
    comm_ok = q_r.msg_cnt < CNT_W'(MSG_TIMEOUT);
    ev[A_NOMSG] = !comm_ok;

    q_nxt.khi_cnt = count(key_voltage > q_r.key_max, q_r.khi_cnt);
    ev[A_KEY_HI] = q_r.khi_cnt >= CNT_W'(KEY_PERSIST);
    q_nxt.klo_cnt = count(key_voltage < q_r.key_min, q_r.klo_cnt);
    ev[A_KEY_LO] = q_r.klo_cnt >= CNT_W'(KEY_PERSIST);

    ev[A_SHORT] = short_s;

    // watchdog only in standby or run
    ev[A_WDOG] = watchdog_fault &&
                 ((q_r.st == ST_STBY) || (q_r.st == ST_RUN));
    ev[A_IN_MISM] = input_mismatch;
    ev[A_SETPT] = setpoint_fault;

    ev[A_OVERV] = virq_s && (dc_link_v >= q_r.ov_lvl);
    ev[A_UNDERV] = virq_s && (dc_link_v < q_r.ov_lvl);

    clr[A_NOMSG] = req_rise && comm_ok;
    clr[A_OVERV] = req_rise && !virq_s;
    clr[A_UNDERV] = req_rise && !virq_s;

    q_nxt.alm = (q_r.alm & ~clr) | ev;

    // sticky irq status, set wins over clear
    q_nxt.irq_st = q_r.irq_st;
    if (wr && paddr == REG_IRQ_CLR) begin
      q_nxt.irq_st = q_r.irq_st & ~pwdata[ALM_W-1:0];
    end
    q_nxt.irq_st = q_nxt.irq_st | (ev & ~q_r.alm);

    // register writes
    if (wr) begin
      case (paddr)
        REG_CTRL: q_nxt.ctrl = pwdata[1:0];
        REG_SET_BAT: q_nxt.set_bat = pwdata[11:0];
        REG_SET_KEY: q_nxt.set_key = pwdata[11:0];
        REG_KEY_MAX: q_nxt.key_max = pwdata[11:0];
        REG_KEY_MIN: q_nxt.key_min = pwdata[11:0];
        REG_OV_LVL: q_nxt.ov_lvl = pwdata[11:0];
        REG_HOME_TOL: q_nxt.home_tol = pwdata[11:0];
        REG_HOME_OFF: q_nxt.home_off = pwdata[11:0];
        REG_IRQ_EN: q_nxt.irq_en = pwdata[ALM_W-1:0];
        default: q_nxt.ctrl = q_r.ctrl;
      endcase
    end

    // read data captured in the setup cycle
    if (setup) begin
      case (paddr)
        REG_CTRL: q_nxt.prdata = {30'h0, q_r.ctrl};
        REG_SET_BAT: q_nxt.prdata = {20'h0, q_r.set_bat};
        REG_SET_KEY: q_nxt.prdata = {20'h0, q_r.set_key};
        REG_KEY_MAX: q_nxt.prdata = {20'h0, q_r.key_max};
        REG_KEY_MIN: q_nxt.prdata = {20'h0, q_r.key_min};
        REG_OV_LVL: q_nxt.prdata = {20'h0, q_r.ov_lvl};
        REG_HOME_TOL: q_nxt.prdata = {20'h0, q_r.home_tol};
        REG_HOME_OFF: q_nxt.prdata = {20'h0, q_r.home_off};
        REG_ALARM: q_nxt.prdata = {15'h0, q_r.alm};
        REG_IRQ_STAT: q_nxt.prdata = {15'h0, q_r.irq_st};
        REG_IRQ_EN: q_nxt.prdata = {15'h0, q_r.irq_en};
        REG_CODES: q_nxt.prdata = q_r.codes;
        REG_STATE: q_nxt.prdata = {30'h0, q_r.st};
        default: q_nxt.prdata = 32'h0000_0000;
      endcase
    end

    // reported code, lowest latched alarm first
    q_nxt.codes = CODE_NONE;
    for (int i = ALM_W - 1; i >= 0; i--) begin
      if (q_r.alm[i]) begin
        q_nxt.codes = code_of(i);
      end
    end

    open_c = |(q_r.alm & MASK_OPEN);
    q_nxt.contactor = ((q_r.st == ST_STBY) || (q_r.st == ST_RUN)) && !open_c;
    q_nxt.brake = !((q_r.st == ST_RUN) && !open_c);
    // any alarm stops traction and pump
    q_nxt.trac = (q_r.st == ST_RUN) && (q_r.alm == '0);
    q_nxt.valves = (q_r.st == ST_RUN) && !open_c;
  end

  // ---------------------------------------------------------------
  // register the state
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      q_r <= '0;
      q_r.st <= ST_BOOT;
      q_r.brake <= 1'b1;
      q_r.set_bat <= RST_VAL12;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel && penable &&
                   (!mapped || (pwrite && (paddr == REG_ALARM ||
                    paddr == REG_IRQ_STAT || paddr == REG_CODES ||
                    paddr == REG_STATE)) ||
                    (!pwrite && paddr == REG_IRQ_CLR));
  assign prdata = q_r.prdata;
  assign main_contactor = q_r.contactor;
  assign electromagnetic_brake = q_r.brake;
  assign traction_output = q_r.trac;
  assign pump_output = q_r.trac;
  assign valve_output = q_r.valves;
  assign canopen_code = q_r.codes[31:16];
  assign display_code = q_r.codes[15:8];
  assign numeric_code = q_r.codes[7:0];
  // level interrupt from enabled sticky bits
  assign irq = |(q_r.irq_st & q_r.irq_en);
endmodule // ias_top
`default_nettype wire

// ===== tb/ias_sup_model.sv
// supervisor link and conversion refresh model for the bench
`timescale 1ns/1ns
`default_nettype none
module ias_sup_model #(
  parameter int PERIOD = 8
) (
  input wire logic clock,
  input wire logic msg_en,
  input wire logic adc_en,
  output logic sup_msg,
  output logic adc_done,
  output logic adc_changed
);
  int cnt = 0;
  // one message and one conversion round per period; rounds keep coming
  // when frozen, with the changed flag low, so the freeze test is real
  always @(posedge clock) begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    sup_msg <= msg_en && cnt == 0;
    adc_done <= cnt == 3;
    adc_changed <= adc_en && cnt[1];
  end
endmodule // ias_sup_model
`default_nettype wire

// ===== tb/ias_properties.sv
// port assertions for the alarm supervisor
`timescale 1ns/1ns
`default_nettype none
module ias_properties import ias_pkg::*; #(
  parameter int unsigned ADC_FREEZE = 50,
  parameter int unsigned MSG_TIMEOUT = 30
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic adc_done,
  input wire logic adc_changed,
  input wire logic [11:0] dc_link_v,
  input wire logic [2:0] high_side_on,
  input wire logic bumper_a,
  input wire logic bumper_b,
  input wire logic sup_msg,
  input wire logic main_contactor,
  input wire logic electromagnetic_brake,
  input wire logic traction_output,
  input wire logic valve_output,
  input wire logic [15:0] canopen_code,
  input wire logic [7:0] display_code,
  input wire logic [7:0] numeric_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic [31:0] code_w;
  logic [31:0] msg_cnt_r;
  logic [31:0] adc_cnt_r;
  logic opened;
  // reported triple and the safe state
  assign code_w = {canopen_code, display_code, numeric_code};
  assign opened = !main_contactor && electromagnetic_brake;
  // ---------------------------------------------------------------
  // cycles since last message and last fresh conversion
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      msg_cnt_r <= 32'h0;
      adc_cnt_r <= 32'h0;
    end else begin
      msg_cnt_r <= sup_msg ? 32'h0 : msg_cnt_r + 32'h1;
      adc_cnt_r <= (adc_done && adc_changed) ? 32'h0 : adc_cnt_r + 32'h1;
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_freeze_opens: assert property (
    adc_cnt_r > ADC_FREEZE + 3 |-> opened)
    else $error("frozen conversions left contactor closed");
  a_bumper_stop: assert property (
    (bumper_a && bumper_b) [*4] |-> ##[1:2] opened)
    else $error("bumper pair did not stop");
  a_pmos_short: assert property (
    dc_link_v == 12'h000 && |high_side_on |-> ##[1:3] opened)
    else $error("shorted switch not caught");
  a_msg_timeout: assert property (
    msg_cnt_r > MSG_TIMEOUT + 2 |-> opened)
    else $error("silent supervisor not caught");
  a_boot_quiet: assert property (
    $rose(rstn) |-> (canopen_code == 16'h0000) [*4])
    else $error("alarm reported during boot");
  a_wdog_latch: assert property (
    canopen_code == CODE_WDOG[31:16] |-> code_w == CODE_WDOG
      ##1 opened && canopen_code != 16'h0000)
    else $error("watchdog report wrong or not held");
  a_nomsg_code: assert property (
    canopen_code == CODE_NOMSG[31:16] |-> code_w == CODE_NOMSG
      && opened && !valve_output)
    else $error("missing message report wrong");
  a_mism_code: assert property (
    canopen_code == CODE_IN_MISM[31:16] |-> code_w == CODE_IN_MISM
      && opened)
    else $error("input mismatch report wrong");
  a_setpt_stop: assert property (
    canopen_code == CODE_SETPT[31:16] |-> code_w == CODE_SETPT
      && !traction_output)
    else $error("setpoint report wrong");
  a_alarm_react: assert property (
    canopen_code != 16'h0000 && canopen_code != CODE_SETPT[31:16]
      |-> opened && !traction_output && !valve_output)
    else $error("alarm without full stop");
  // main scenarios reached
  c_nomsg: cover property (canopen_code == CODE_NOMSG[31:16]);
  c_setpt: cover property (canopen_code == CODE_SETPT[31:16]);
  c_restart: cover property ($fell(canopen_code != 16'h0000));
endmodule // ias_properties
bind ias_top ias_properties #(
  .ADC_FREEZE(ADC_FREEZE),
  .MSG_TIMEOUT(MSG_TIMEOUT)
) ias_properties_i (
  .clock, .rstn, .adc_done, .adc_changed, .dc_link_v, .high_side_on,
  .bumper_a, .bumper_b, .sup_msg, .main_contactor, .electromagnetic_brake,
  .traction_output, .valve_output, .canopen_code, .display_code,
  .numeric_code
);
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the alarm supervisor
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ias_pkg::*;
  logic clock, rstn, psel, penable, pwrite, pready, pslverr, er, irq;
  logic [7:0] paddr, display_code, numeric_code;
  logic [31:0] pwdata, prdata, rd;
  logic adc_done, adc_changed, sup_msg, msg_en, adc_en;
  logic [11:0] key_voltage, dc_link_v, rotor_angle;
  logic [2:0] high_side_on;
  logic bumper_a, bumper_b, board_present, short_detect, volt_irq;
  logic pwm_data_valid, index_pulse, watchdog_fault, input_mismatch;
  logic setpoint_fault, motion_request, main_contactor, pump_output;
  logic electromagnetic_brake, traction_output, valve_output;
  logic [15:0] canopen_code;
  int err_total = 0;
  int tests_run = 0;
  int ev_bit[10] = '{A_WDOG, A_IN_MISM, A_SETPT, A_ANALOG, A_PMOS,
    A_OVERV, A_UNDERV, A_KEY_LO, A_HOME, A_SHORT};
  logic [31:0] ev_code[10] = '{CODE_WDOG, CODE_IN_MISM, CODE_SETPT,
    CODE_ANALOG, CODE_OTHER, CODE_OVERV, CODE_UNDERV, CODE_OTHER,
    CODE_OTHER, CODE_OTHER};

  ias_top #(.ADC_FREEZE(50), .KEY_PERSIST(20), .MSG_TIMEOUT(30)) ias_top_i (
    .clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .adc_done, .adc_changed, .key_voltage, .dc_link_v,
    .high_side_on, .bumper_a, .bumper_b, .board_present, .short_detect,
    .volt_irq, .pwm_data_valid, .index_pulse, .rotor_angle, .sup_msg,
    .watchdog_fault, .input_mismatch, .setpoint_fault, .motion_request,
    .main_contactor, .electromagnetic_brake, .traction_output, .pump_output,
    .valve_output, .canopen_code, .display_code, .numeric_code, .irq);
  ias_sup_model ias_sup_model_i (.clock, .msg_en, .adc_en, .sup_msg,
    .adc_done, .adc_changed);

  // 50 mhz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic hang(input int n);
    if (n == 0) begin
      err_total++;
      $display("ERROR t=%0t wait ran out", $time);
      tally_and_finish();
    end
  endtask

  // apb transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    for (n = 20; n > 0; n--) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    hang(n);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask

  // key cycle; odd puts startup faults on the pins
  task automatic do_reset(input logic odd);
    rstn <= 1'b0;
    {bumper_a, bumper_b, short_detect, volt_irq, index_pulse} <= 5'h00;
    {watchdog_fault, input_mismatch, setpoint_fault} <= {odd, 2'h0};
    {motion_request, board_present, pwm_data_valid} <= {1'b0, !odd, !odd};
    {msg_en, adc_en, high_side_on} <= 5'h18;
    {key_voltage, dc_link_v, rotor_angle} <= {odd ? 12'h064 : 12'h0,
      12'h100, 12'h0};
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
  endtask

  task automatic wait_alarm();
    int n;
    for (n = 150; n > 0; n--) begin
      @(posedge clock);
      if (canopen_code !== 16'h0) break;
    end
    hang(n);
    repeat (2) @(posedge clock);
  endtask

  task automatic t_regs();
    logic [7:0] ba[4] = '{8'h40, REG_IRQ_CLR, REG_ALARM, 8'h06};
    do_reset(1'b0);
    for (int i = 0; i < 14; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      if (i != 10 && i != 13) chk(rd, 32'h0);
    end
    apb(1'b0, REG_STATE, 32'h0);
    chk(rd, {30'h0, ST_STBY});
    apb(1'b1, REG_SET_BAT, 32'hffff_f123);
    apb(1'b0, REG_SET_BAT, 32'h0);
    chk(rd, 32'h0000_0123);
    for (int i = 0; i < 4; i++) begin
      apb(i == 2, ba[i], 32'hffff_ffff);
      chk({31'h0, er}, 32'h1);
    end
    apb(1'b0, REG_ALARM, 32'h0);
    chk(rd, 32'h0);
  endtask

  task automatic t_startup();
    do_reset(1'b1);
    apb(1'b1, REG_CTRL, 32'h3);
    repeat (40) @(posedge clock);
    apb(1'b0, REG_ALARM, 32'h0);
    chk(rd, 32'h0000_1992);
    chk({canopen_code, display_code, numeric_code}, CODE_OTHER);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, REG_IRQ_EN, 32'h80);
    @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk(rd, 32'h0000_1992);
    apb(1'b1, REG_IRQ_CLR, 32'h80);
    @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk(rd, 32'h0000_1912);
  endtask

  task automatic t_bumper();
    do_reset(1'b0);
    pwm_data_valid <= 1'b0; // sensor not configured, no alarm
    repeat (10) @(posedge clock);
    bumper_a <= 1'b1;
    repeat (10) @(posedge clock);
    chk({canopen_code, main_contactor}, 17'h1);
    bumper_b <= 1'b1;
    wait_alarm();
    apb(1'b0, REG_ALARM, 32'h0);
    chk(rd, 32'h4);
    {bumper_a, bumper_b} <= 2'h0;
    repeat (10) @(posedge clock);
    chk({main_contactor, electromagnetic_brake}, 2'b01);
  endtask

  task automatic t_nomsg();
    do_reset(1'b0);
    repeat (10) @(posedge clock);
    msg_en <= 1'b0;
    wait_alarm();
    chk({canopen_code, display_code, numeric_code}, CODE_NOMSG);
    motion_request <= 1'b1;
    repeat (5) @(posedge clock);
    chk({16'h0, canopen_code}, {16'h0, CODE_NOMSG[31:16]});
    {motion_request, msg_en} <= 2'b01;
    repeat (20) @(posedge clock);
    motion_request <= 1'b1;
    repeat (5) @(posedge clock);
    chk({canopen_code, main_contactor}, 17'h1);
  endtask

  task automatic t_event(input int k);
    do_reset(1'b0);
    repeat (10) @(posedge clock);
    if (k == 6) apb(1'b1, REG_OV_LVL, 32'h800);
    if (k == 7) apb(1'b1, REG_KEY_MIN, 32'h50);
    if (k == 8) apb(1'b1, REG_HOME_TOL, 32'h4);
    motion_request <= 1'b1;
    repeat (5) @(posedge clock);
    case (k)
      0: watchdog_fault <= 1'b1;
      1: input_mismatch <= 1'b1;
      2: setpoint_fault <= 1'b1;
      3: adc_en <= 1'b0;
      4: {dc_link_v, high_side_on} <= {12'h0, 3'h2};
      5, 6: volt_irq <= 1'b1;
      8: {rotor_angle, index_pulse} <= {12'h00a, 1'b1};
      9: short_detect <= 1'b1;
      default: ;
    endcase
    wait_alarm();
    apb(1'b0, REG_ALARM, 32'h0);
    chk(rd, 32'h1 << ev_bit[k]);
    chk({canopen_code, display_code, numeric_code}, ev_code[k]);
    chk({main_contactor, traction_output, pump_output},
        k == 2 ? 3'b100 : 3'b000);
    if (k != 2) chk({electromagnetic_brake, valve_output}, 2'b10);
  endtask

  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    t_regs();
    t_startup();
    t_bumper();
    t_nomsg();
    for (int k = 0; k < 10; k++) t_event(k);
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
